// >>> design/fwg_consts.vh
// constants of the flash write guard host controller
`ifndef FWG_CONSTS_VH
`define FWG_CONSTS_VH
`define FWG_REG_CTRL     8'h00
`define FWG_REG_ADDR     8'h04
`define FWG_REG_DATA     8'h08
`define FWG_REG_CMD      8'h0C
`define FWG_REG_STATUS   8'h10
`define FWG_REG_RDDATA   8'h14
`define FWG_CTRL_HV      0
`define FWG_CTRL_GUARD   1
`define FWG_CMD_WRITE    0
`define FWG_CMD_READ     1
`define FWG_CMD_ENTER    2
`define FWG_CMD_EXIT     3
`define FWG_CMD_PROG     4
`define FWG_ST_BUSY      0
`define FWG_ST_OVERLAY   1
`define FWG_ST_REJECT    2
`define FWG_GLITCH_NS    5
`define FWG_CLK_NS       4
`define FWG_PULSE_CYC    ((`FWG_GLITCH_NS+`FWG_CLK_NS-1)/`FWG_CLK_NS+1)
`define FWG_UNLOCK_A1    22'h000555
`define FWG_UNLOCK_D1    16'h00AA
`define FWG_UNLOCK_A2    22'h0002AA
`define FWG_UNLOCK_D2    16'h0055
`define FWG_ENTER_D3     16'h0088
`define FWG_EXIT_D3      16'h0090
`define FWG_EXIT_D4      16'h0000
`define FWG_PROG_D3      16'h00A0
`endif

// >>> design/fwg_flash_host.v
// host controller that drives the flash bus pins under AXI4-Lite orders
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fwg_consts.vh"
// Contract
// RL1 - temporary unprotect only while host raises clear pin to high voltage
// RL2 - during temporary unprotect protected sectors accept program and erase
// RL3 - dropping high voltage restores all earlier protection
// RL4 - boot guard low keeps outermost boot sectors protected in that mode
// RL5 - device holds a fixed secured region indicator bit
// RL6 - entry sequence maps secured region onto boot sector addresses
// RL7 - overlay stays until exit sequence or power loss
// RL8 - power-up or hardware clear drops the overlay
// RL9 - factory locked parts reject any change to the secured region
// RL10 - serial identity sits in a fixed secured region window
// RL11 - customer parts read freely, program and lock once, never erase
// RL12 - no accelerated or bypass programming into the secured region
// RL13 - lock uses three-cycle entry then protect algorithm
// RL14 - locked secured region can never be changed
// RL15 - host sends exit sequence before touching the rest of the array; host rejects only PROG while overlay is set
// RL16 - program or erase only after unlock cycles sent by host
// RL17 - below lockout threshold device ignores writes
// RL18 - strobe pulses under glitch limit start no write
// RL19 - write only with select and write strobe low, output strobe high
// RL20 - power-up with write asserted ignores next write strobe edge
// RL21 - boot guard low blocks outermost boot sectors
// RL22 - program allowed only if unprotected or temporarily unprotected
module fwg_flash_host (
   input  wire        clk,
   input  wire        reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [21:0] flashAddr,
   output reg  [15:0] flashDqOut,
   output reg         flashDqOe,
   input  wire [15:0] flashDqIn,
   output reg         chipSelect_n,
   output reg         writeStrobe_n,
   output reg         outputStrobe_n,
   output reg         clearHighVoltage,
   output reg         clearPin_n,
   output reg         bootGuardAccelPin
);
   localparam IDLE  = 4'b0001;
   localparam SETUP = 4'b0010;
   localparam PULSE = 4'b0100;
   localparam HOLD  = 4'b1000;

   reg  [3:0]  state;
   reg  [21:0] regAddr;
   reg  [15:0] regData;
   reg  [15:0] rdData;
   reg  [15:0] rdSync1;
   reg  [15:0] rdSync2;
   reg  [1:0]  ctrl;
   reg         overlay;
   reg         reject;
   reg  [2:0]  op;
   reg  [2:0]  step;
   reg  [2:0]  steps;
   reg  [3:0]  cnt;
   reg         awHeld;
   reg         wHeld;
   reg  [7:0]  awAddr;
   reg  [31:0] wData;
   reg  [21:0] cycAddr;
   reg  [15:0] cycData;
   wire        busy = (state != IDLE);
   wire        doWrite = awHeld && wHeld && !s_axi_bvalid;

   // cycle address and data for each step of the current sequence
   always @* begin
      cycAddr = `FWG_UNLOCK_A1;
      cycData = `FWG_UNLOCK_D1;
      if (step == 3'd1) begin
         cycAddr = `FWG_UNLOCK_A2;
         cycData = `FWG_UNLOCK_D2;
      end else if (step == 3'd2) begin
         cycAddr = `FWG_UNLOCK_A1;
         case (op)
            3'd2:    cycData = `FWG_ENTER_D3;
            3'd3:    cycData = `FWG_EXIT_D3;
            3'd4:    cycData = `FWG_PROG_D3;
            default: cycData = regData;
         endcase
         if (op == 3'd0 || op == 3'd1)
            cycAddr = regAddr;
      end else if (step == 3'd3) begin
         cycAddr = regAddr;
         cycData = (op == 3'd3) ? `FWG_EXIT_D4 : regData;
      end
      if (op == 3'd0 || op == 3'd1) begin
         cycAddr = regAddr;
         cycData = regData;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h00000000;
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= 8'h00;
         wData  <= 32'h00000000;
         regAddr <= 22'h000000;
         regData <= 16'h0000;
         rdData  <= 16'h0000;
         rdSync1 <= 16'h0000;
         rdSync2 <= 16'h0000;
         ctrl    <= 2'b10;
         overlay <= 1'b0;
         reject  <= 1'b0;
         op    <= 3'd0;
         step  <= 3'd0;
         steps <= 3'd0;
         cnt   <= 4'h0;
         state <= IDLE;
         flashAddr <= 22'h000000;
         flashDqOut <= 16'h0000;
         flashDqOe <= 1'b0;
         chipSelect_n <= 1'b1;
         writeStrobe_n <= 1'b1;
         outputStrobe_n <= 1'b1;
         clearHighVoltage <= 1'b0;
         clearPin_n <= 1'b0;
         bootGuardAccelPin <= 1'b1;
      end else begin
         rdSync1 <= flashDqIn;
         rdSync2 <= rdSync1;
         clearPin_n <= 1'b1;
         clearHighVoltage <= ctrl[`FWG_CTRL_HV];          // [RL1] [RL3]
         bootGuardAccelPin <= ctrl[`FWG_CTRL_GUARD];      // [RL4] [RL21]
         s_axi_awready <= !awHeld && !s_axi_awready;
         s_axi_wready  <= !wHeld && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awAddr)
               `FWG_REG_CTRL: ctrl <= wData[1:0];
               `FWG_REG_ADDR: regAddr <= wData[21:0];
               `FWG_REG_DATA: regData <= wData[15:0];
               `FWG_REG_CMD: begin
                  if (busy || wData[2:0] > 3'd4)
                     s_axi_bresp <= 2'b10;
                  else if (wData[2:0] == 3'd4 && overlay) begin
                     reject <= 1'b1;                      // [RL12] [RL15]
                     s_axi_bresp <= 2'b10;
                  end else begin
                     op <= wData[2:0];
                     reject <= 1'b0;
                     step <= (wData[2:0] < 3'd2) ? 3'd3 : 3'd0;
                     steps <= (wData[2:0] == 3'd2) ? 3'd2 : 3'd3; // [RL13]
                     state <= SETUP;
                  end
               end
               default: s_axi_bresp <= 2'b10;
            endcase
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `FWG_REG_CTRL:   s_axi_rdata <= {30'h0, ctrl};
               `FWG_REG_ADDR:   s_axi_rdata <= {10'h0, regAddr};
               `FWG_REG_DATA:   s_axi_rdata <= {16'h0, regData};
               `FWG_REG_STATUS: s_axi_rdata <= {29'h0, reject, overlay, busy};
               `FWG_REG_RDDATA: s_axi_rdata <= {16'h0, rdData};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         case (state)
            IDLE: begin
               chipSelect_n <= 1'b1;
               writeStrobe_n <= 1'b1;
               outputStrobe_n <= 1'b1;
               flashDqOe <= 1'b0;
            end
            SETUP: begin
               flashAddr <= cycAddr;
               flashDqOut <= cycData;
               flashDqOe <= (op != 3'd1);
               outputStrobe_n <= (op != 3'd1) ? 1'b1 : 1'b0; // [RL19]
               chipSelect_n <= 1'b0;
               cnt <= 4'h0;
               state <= PULSE;
            end
            PULSE: begin
               writeStrobe_n <= (op == 3'd1);             // [RL19] [RL16]
               cnt <= cnt + 4'h1;
               if (cnt == `FWG_PULSE_CYC) begin            // [RL18]
                  if (op == 3'd1)
                     rdData <= rdSync2;
                  writeStrobe_n <= 1'b1;
                  state <= HOLD;
               end
            end
            HOLD: begin
               chipSelect_n <= 1'b1;
               outputStrobe_n <= 1'b1;
               flashDqOe <= 1'b0;
               if (step >= steps) begin
                  if (op == 3'd2)
                     overlay <= 1'b1;                     // [RL6]
                  if (op == 3'd3)
                     overlay <= 1'b0;                     // [RL7] [RL15]
                  state <= IDLE;
               end else begin
                  step <= step + 3'd1;
                  state <= SETUP;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end
endmodule

// >>> verification/fwg_flash_host_chk.sv
// checker of the host flash bus pins
`timescale 1ns/1ps
`include "fwg_consts.vh"
module fwg_flash_host_chk (
   input wire        clk,
   input wire        reset,
   input wire [21:0] flashAddr,
   input wire [15:0] flashDqOut,
   input wire        flashDqOe,
   input wire        writeStrobe_n,
   input wire        chipSelect_n,
   input wire        outputStrobe_n,
   input wire        clearHighVoltage,
   input wire        clearPin_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_cyc(a, d);
      $fell(writeStrobe_n) && flashAddr == a && flashDqOut == d;
   endsequence
   sequence s_first;
      s_cyc(`FWG_UNLOCK_A1, `FWG_UNLOCK_D1);
   endsequence
   sequence s_second;
      s_cyc(`FWG_UNLOCK_A2, `FWG_UNLOCK_D2);
   endsequence
   property p_hv;
      clearHighVoltage |-> clearPin_n;
   endproperty
   property p_wr;
      !writeStrobe_n |-> !chipSelect_n && outputStrobe_n && flashDqOe;
   endproperty
   property p_rd;
      !outputStrobe_n |-> writeStrobe_n && !flashDqOe;
   endproperty
   property p_pulse;
      $fell(writeStrobe_n) |-> !writeStrobe_n [*3] ##1 writeStrobe_n;
   endproperty
   property p_hold;
      !writeStrobe_n |=> writeStrobe_n
         || ($stable(flashAddr) && $stable(flashDqOut));
   endproperty
   property p_unlock;
      s_first |-> ##[1:20] s_second;
   endproperty
   property p_third;
      s_second |-> ##[1:20] ($fell(writeStrobe_n) && flashAddr == 22'h555);
   endproperty
   a_hv: assert property (p_hv) else $error("hv without clear high");
   a_wr: assert property (p_wr) else $error("bad write strobes");
   a_rd: assert property (p_rd) else $error("read during write");
   a_pulse: assert property (p_pulse) else $error("short pulse");
   a_hold: assert property (p_hold) else $error("bus moved");
   a_unlock: assert property (p_unlock) else $error("no 2nd unlock");
   a_third: assert property (p_third) else $error("no command");
endmodule
bind fwg_flash_host fwg_flash_host_chk u_fwg_flash_host_chk (.clk, .reset,
   .flashAddr, .flashDqOut, .flashDqOe, .writeStrobe_n, .chipSelect_n,
   .outputStrobe_n, .clearHighVoltage, .clearPin_n);

// >>> verification/fwg_flash_model.sv
// behavioural flash device on the far side of the host bus
`timescale 1ns/1ps
`include "fwg_consts.vh"
module fwg_flash_model #(
   parameter        FACTORY_LOCKED = 1'b0,
   parameter [15:0] SERIAL         = 16'h5A5A // arbitrary identity value
) (
   input wire [21:0] flashAddr,
   input wire [15:0] flashDqOut,
   input wire        writeStrobe_n,
   input wire        chipSelect_n,
   input wire        outputStrobe_n,
   input wire        clearHighVoltage,
   input wire        clearPin_n,
   input wire        bootGuardAccelPin,
   output reg [15:0] flashDqIn
);
   reg [15:0] mem [0:15];
   reg [15:0] sec [0:15];
   reg [2:0]  step;
   reg        overlay;
   reg        locked;
   reg        skipEdge;
   realtime   tFall;
   wire [3:0] i = flashAddr[3:0];
   wire       boot = &flashAddr[21:13];
   wire       okMain = (!boot || bootGuardAccelPin)
       && (!flashAddr[21] || clearHighVoltage);
   wire [15:0] rdVal = (overlay && boot) ? sec[i] : mem[i];
   initial begin
      for (int k = 0; k < 16; k++) begin
         mem[k] = 16'hFFFF;
         sec[k] = SERIAL;
      end
      {step, overlay} = 4'h0;
      locked = FACTORY_LOCKED;
      skipEdge = 1'b0;
      flashDqIn = 16'h0000;
   end
   always @(chipSelect_n or outputStrobe_n or rdVal)
      flashDqIn = (!chipSelect_n && !outputStrobe_n) ? rdVal : ~flashDqIn;
   always @(negedge writeStrobe_n) tFall = $realtime;
   always @(negedge clearPin_n) begin
      step = 3'h0;
      overlay = 1'b0;
      skipEdge = (chipSelect_n === 1'b0) && (writeStrobe_n === 1'b0)
                 && (outputStrobe_n === 1'b1);
   end
   always @(posedge writeStrobe_n)
      if (skipEdge)
         skipEdge = 1'b0;
      else if (!chipSelect_n && outputStrobe_n && clearPin_n
          && $realtime - tFall >= `FWG_GLITCH_NS)
         case (step)
            0: step = (flashAddr == 22'h555 && flashDqOut == 16'hAA) ? 1 : 0;
            1:
               step = (flashAddr == 22'h2AA && flashDqOut == 16'h55) ? 2 : 0;
            2: begin
               step = (flashDqOut == 16'hA0) ? 3'h3
                    : (flashDqOut == 16'h90) ? 3'h4 : 3'h0;
               if (flashDqOut == 16'h88) overlay = 1'b1;
            end
            3: begin
               step = 3'h0;
               if (overlay && boot) begin
                  if (!locked) sec[i] = sec[i] & flashDqOut;
                  locked = 1'b1;
               end else if (okMain) mem[i] = mem[i] & flashDqOut;
            end
            default: begin
               step = 3'h0;
               overlay = 1'b0;
            end
         endcase
endmodule

// >>> verification/fwg_flash_host_tb.sv
// self-checking bench of the flash host controller
`timescale 1ns/1ps
`include "fwg_consts.vh"
module fwg_flash_host_tb;
   reg clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   reg s_axi_arvalid, s_axi_rready;
   reg [7:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata, rv;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, flashDqOe, chipSelect_n, writeStrobe_n;
   wire outputStrobe_n, clearHighVoltage, clearPin_n, bootGuardAccelPin;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [21:0] flashAddr;
   wire [15:0] flashDqOut, flashDqIn;
   integer mismatches = 0;
   integer check_count = 0;
   fwg_flash_host u_fwg_flash_host (.clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flashAddr,
      .flashDqOut, .flashDqOe, .flashDqIn, .chipSelect_n, .writeStrobe_n,
      .outputStrobe_n, .clearHighVoltage, .clearPin_n, .bootGuardAccelPin);
   fwg_flash_model u_fwg_flash_model (.flashAddr, .flashDqOut,
      .writeStrobe_n, .chipSelect_n, .outputStrobe_n, .clearHighVoltage,
      .clearPin_n, .bootGuardAccelPin, .flashDqIn);
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task step(inout integer n);
      @(posedge clk);
      n = n + 1;
      if (n > 400) begin
         mismatches++;
         $display("unexpected at %0t: no answer", $time);
         end_of_test;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      integer n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         step(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task rd(input [7:0] a, input [1:0] er);
      integer n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         step(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      cmp({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task wait_idle;
      integer n;
      n = 0;
      do begin
         step(n);
         rd(`FWG_REG_STATUS, 2'd0);
      end while (rv[`FWG_ST_BUSY] !== 1'b0);
   endtask
   task op(input [2:0] cmd, input [21:0] a, input [15:0] d);
      wr(`FWG_REG_ADDR, {10'h0, a}, 2'd0);
      wr(`FWG_REG_DATA, {16'h0, d}, 2'd0);
      wr(`FWG_REG_CMD, {29'h0, cmd}, 2'd0);
      wait_idle;
   endtask
   task fr(input [21:0] a, input [15:0] e);
      op(`FWG_CMD_READ, a, 16'h0);
      rd(`FWG_REG_RDDATA, 2'd0);
      cmp(rv, {16'h0, e});
   endtask
   task t_protect;
      op(`FWG_CMD_PROG, 22'h000003, 16'h1234);
      fr(22'h000003, 16'h1234);
      op(`FWG_CMD_WRITE, 22'h000003, 16'h0000);
      fr(22'h000003, 16'h1234);
      op(`FWG_CMD_PROG, 22'h200005, 16'h00FF);
      fr(22'h200005, 16'hFFFF);
      wr(`FWG_REG_CTRL, 32'h3, 2'd0);
      op(`FWG_CMD_PROG, 22'h200005, 16'h00FF);
      fr(22'h200005, 16'h00FF);
      wr(`FWG_REG_CTRL, 32'h1, 2'd0);
      op(`FWG_CMD_PROG, 22'h3FFF07, 16'h0000);
      fr(22'h3FFF07, 16'hFFFF);
      wr(`FWG_REG_CTRL, 32'h2, 2'd0);
      op(`FWG_CMD_PROG, 22'h200005, 16'h000F);
      fr(22'h200005, 16'h00FF);
      wr(`FWG_REG_CMD, {29'h0, 3'd4}, 2'd0);
      wr(`FWG_REG_CMD, {29'h0, 3'd4}, 2'd2);
      wait_idle;
      wr(`FWG_REG_CMD, 32'h5, 2'd2);
      fr(22'h200005, 16'h00FF);
      $display("protect test done");
   endtask
   task t_region;
      op(`FWG_CMD_ENTER, 22'h0, 16'h0);
      cmp(rv & 32'h2, 32'h2);
      fr(22'h3FFF02, 16'h5A5A);
      wr(`FWG_REG_CMD, {29'h0, 3'd4}, 2'd2);
      rd(`FWG_REG_STATUS, 2'd0);
      cmp(rv & 32'h4, 32'h4);
      op(`FWG_CMD_EXIT, 22'h0, 16'h0);
      fr(22'h3FFF02, 16'hFFFF);
      op(`FWG_CMD_ENTER, 22'h0, 16'h0);
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      fr(22'h3FFF02, 16'hFFFF);
      rd(`FWG_REG_STATUS, 2'd0);
      cmp(rv & 32'h6, 32'h0);
      wr(8'h40, 32'h0, 2'd2);
      rd(8'h40, 2'd2);
      $display("region test done");
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'b1000;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      s_axi_wdata = 32'h0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_protect;
      t_region;
      end_of_test;
   end
endmodule
